// file: rtl/ress_defines.vh
// constants for the reset and exception entry sequencer
//
// Summary of operation
// (R1) reset always wins over any pending interrupt request
// (R2) reset exception processing starts as soon as reset is released
// (R3) interrupt entry waits for the current instruction or exception to finish
// (R4) a low init pin stops all processing at once and enters reset
// (R5) outside source holds init pin low at least ten clocks when running
// (R6) at power-up outside source holds init pin low until clock is stable
// (R7) boot select high: release reset when init pin returns high
// (R8) boot select low: release 8,192 clocks after boot select rises
// (R9) reset processing returns core state and peripheral registers to initial values
// (R10) reset processing sets the global interrupt mask flag to one
// (R11) load program counter from two-byte vector at lowest addresses, then fetch
// (R12) outside source holds init pin low while power is applied or removed
// (R13) all interrupts masked after reset until first instruction executes
// (R14) pins synchronised; init pin reassertion restarts the release count
`ifndef RESS_DEFINES_VH
`define RESS_DEFINES_VH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RESS_CLK_MHZ        125
`define RESS_MIN_HOLD_CYC   10
`define RESS_BOOT_DELAY_CYC 8192
`define RESS_CNT_W          14
`define RESS_BOOT_LAST_CNT  14'h1fff

// ----------------------------------------------------------------------------
// vectors and flags
// ----------------------------------------------------------------------------
`define RESS_VEC_LO_ADDR    16'h0000
`define RESS_VEC_HI_ADDR    16'h0001
`define RESS_IMASK_BIT      7
`define RESS_IMASK_RESET    1'b1
`define RESS_FLAGS_RESET    8'h80
`define RESS_PC_RESET       16'h0000

`endif

// file: rtl/ress_sync.v
// two-flop synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none

module ress_sync (
  input  wire sys_clk_i,
  input  wire rst_n_i,
  input  wire pin_i,
  input  wire init_val_i,
  output reg  pin_o
);

  reg meta;

  // ----------------------------------------------------------------------------
  // first flop feeds only the second
  // ----------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta  <= init_val_i; // level chosen at hookup
      pin_o <= init_val_i;
    end else begin
      meta  <= pin_i;
      pin_o <= meta;
    end
  end

endmodule

`default_nettype wire

// file: rtl/ress_seq.v
// reset and exception entry sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ress_defines.vh"

module ress_seq (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire        external_init_pin_n_i,
  input  wire        boot_select_pin_i,
  input  wire        irq_req_i,
  input  wire        insn_done_i,
  input  wire        exc_busy_i,
  input  wire        rd_valid_i,
  input  wire [7:0]  rd_data_i,
  output wire        core_reset_o,
  output wire        periph_reset_o,
  output reg         rd_req_o,
  output reg  [15:0] rd_addr_o,
  output reg  [15:0] program_counter_o,
  output reg         pc_load_o,
  output reg         fetch_start_o,
  output reg  [7:0]  flag_register_o,
  output reg         reset_exc_o,
  output reg         irq_take_o,
  output wire        irq_masked_o
);

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  wire init_pin_s;
  wire boot_sel_s;

  ress_sync u_sync_init (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      (external_init_pin_n_i),
    .init_val_i (1'b0),
    .pin_o      (init_pin_s)
  ); // R14

  ress_sync u_sync_boot (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      (boot_select_pin_i),
    .init_val_i (1'b0),
    .pin_o      (boot_sel_s)
  ); // R14

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  // binary state codes; the first three make up the reset state proper
  localparam [2:0] ST_RESET     = 3'b000;
  localparam [2:0] ST_WAIT_BOOT = 3'b001;
  localparam [2:0] ST_COUNT     = 3'b010;
  localparam [2:0] ST_INIT      = 3'b011;
  localparam [2:0] ST_VEC_HI    = 3'b100;
  localparam [2:0] ST_VEC_LO    = 3'b101;
  localparam [2:0] ST_FIRST     = 3'b110;
  localparam [2:0] ST_RUN       = 3'b111;

  reg [2:0]              state;
  reg [2:0]              next_state;
  reg [`RESS_CNT_W-1:0]  cnt;
  reg                    boot_prev;
  reg                    strap_boot;

  // ----------------------------------------------------------------------------
  // state decoding, shared by outputs and the vector fetch
  // ----------------------------------------------------------------------------
  // core stopped and no vector read started yet
  function is_held(input [2:0] st);
    is_held = (st == ST_RESET) || (st == ST_WAIT_BOOT) || (st == ST_COUNT);
  endfunction

  // a vector byte read is outstanding in this state
  function is_vec_fetch(input [2:0] st);
    is_vec_fetch = (st == ST_VEC_HI) || (st == ST_VEC_LO);
  endfunction

  // high byte of the vector sits at the lower address
  function [15:0] vec_addr(input [2:0] st);
    vec_addr = (st == ST_VEC_LO) ? `RESS_VEC_HI_ADDR : `RESS_VEC_LO_ADDR;
  endfunction

  // boot rise taken from the synchronised level, so it comes two edges late
  wire boot_rise = boot_sel_s & ~boot_prev;
  wire in_reset  = is_held(state);

  // qualified events; a low pin voids any vector byte or interrupt in flight
  wire vec_byte_ok = rd_valid_i && init_pin_s;
  wire count_done  = (cnt == `RESS_BOOT_LAST_CNT);
  wire irq_ok      = init_pin_s && irq_req_i && !irq_masked_o &&
                     insn_done_i && !exc_busy_i;

  // core and peripherals held while in reset or being initialised
  assign core_reset_o   = in_reset || (state == ST_INIT); // R9
  assign periph_reset_o = core_reset_o; // R9
  assign irq_masked_o   = flag_register_o[`RESS_IMASK_BIT] || (state != ST_RUN); // R13

  // ----------------------------------------------------------------------------
  // next state; pin low overrides everything, including interrupts
  // ----------------------------------------------------------------------------
  always @* begin
    next_state = state;
    if (!init_pin_s) begin
      next_state = ST_RESET; // R4 R1
    end else begin
      case (state)
        ST_RESET: begin
          if (strap_boot) begin
            next_state = ST_INIT; // R7 R2
          end else begin
            next_state = ST_WAIT_BOOT; // R8
          end
        end
        ST_WAIT_BOOT: begin
          if (boot_rise) begin
            next_state = ST_COUNT; // R8
          end
        end
        // a pin reasserted mid-count takes the branch above and starts over
        ST_COUNT: begin
          if (count_done) begin
            next_state = ST_INIT; // R8 R2
          end
        end
        ST_INIT: begin
          next_state = ST_VEC_HI;
        end
        ST_VEC_HI: begin
          if (rd_valid_i) begin
            next_state = ST_VEC_LO;
          end
        end
        ST_VEC_LO: begin
          if (rd_valid_i) begin
            next_state = ST_FIRST;
          end
        end
        // interrupts stay locked out until the first instruction has run
        ST_FIRST: begin
          if (insn_done_i) begin
            next_state = ST_RUN; // R13
          end
        end
        ST_RUN: begin
          next_state = ST_RUN;
        end
        default: begin
          next_state = ST_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // registers; count restarts whenever reset is reasserted
  // ----------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      // every output back to its initial value, mask flag set
      state             <= ST_RESET;
      cnt               <= {`RESS_CNT_W{1'b0}};
      boot_prev         <= 1'b0;
      strap_boot        <= 1'b0;
      rd_req_o          <= 1'b0;
      rd_addr_o         <= `RESS_VEC_LO_ADDR;
      program_counter_o <= `RESS_PC_RESET;
      pc_load_o         <= 1'b0;
      fetch_start_o     <= 1'b0;
      flag_register_o   <= `RESS_FLAGS_RESET;
      reset_exc_o       <= 1'b0;
      irq_take_o        <= 1'b0;
    end else begin
      state         <= next_state;
      boot_prev     <= boot_sel_s;
      pc_load_o     <= 1'b0;
      fetch_start_o <= 1'b0;
      irq_take_o    <= 1'b0;
      reset_exc_o   <= 1'b0;
      // boot mode sampled while the pin is low, so the level at release decides
      if (!init_pin_s) begin
        strap_boot <= boot_sel_s;
      end
      // the count only advances while the pin stays high
      if (state == ST_COUNT && init_pin_s) begin
        cnt <= cnt + 1'b1;
      end else begin
        cnt <= {`RESS_CNT_W{1'b0}}; // R14
      end
      // reset exception entry: mask set before any vector is read
      if (next_state == ST_INIT) begin
        reset_exc_o <= 1'b1; // R2
        flag_register_o <= `RESS_FLAGS_RESET;
        flag_register_o[`RESS_IMASK_BIT] <= `RESS_IMASK_RESET; // R10
      end
      // vector fetch: high byte at the lower address
      rd_req_o <= is_vec_fetch(next_state);
      if (is_vec_fetch(next_state)) begin
        rd_addr_o <= vec_addr(next_state); // R11
      end
      if (state == ST_VEC_HI && vec_byte_ok) begin
        program_counter_o[15:8] <= rd_data_i; // R11
      end
      if (state == ST_VEC_LO && vec_byte_ok) begin
        program_counter_o[7:0] <= rd_data_i;
        pc_load_o              <= 1'b1;
        fetch_start_o          <= 1'b1; // R11
      end
      // interrupt accepted only at an instruction or exception boundary
      if (state == ST_RUN && irq_ok) begin
        irq_take_o <= 1'b1; // R3 R1
      end
    end
  end

endmodule

`default_nettype wire

// file: verification/ress_seq_asserts.sv
// port assertions for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module ress_chk (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        external_init_pin_n_i,
  input wire logic        rd_valid_i,
  input wire logic        core_reset_o,
  input wire logic        periph_reset_o,
  input wire logic        rd_req_o,
  input wire logic [15:0] rd_addr_o,
  input wire logic        pc_load_o,
  input wire logic        fetch_start_o,
  input wire logic [7:0]  flag_register_o,
  input wire logic        reset_exc_o,
  input wire logic        irq_take_o,
  input wire logic        irq_masked_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // three low samples cover the two-flop synchroniser delay
  a_init_stops_all: assert property (!external_init_pin_n_i [*3] |=> core_reset_o) else $error("no reset");
  a_reset_beats_irq: assert property (core_reset_o |-> !irq_take_o && !pc_load_o) else $error("irq in reset");
  a_irq_after_mask: assert property (irq_take_o |-> !$past(irq_masked_o)) else $error("masked irq taken");
  a_mask_on_exc: assert property (reset_exc_o |-> flag_register_o[7]) else $error("mask flag clear");
  a_exc_then_read: assert property (reset_exc_o |-> ##[1:2] rd_req_o) else $error("no vector read");
  a_vec_low_first: assert property ($rose(rd_req_o) |-> rd_addr_o == 16'h0000) else $error("bad first addr");
  a_vec_then_next: assert property (rd_req_o && rd_valid_i && rd_addr_o == 16'h0000 |=> rd_addr_o == 16'h0001)
    else $error("bad second addr");
  a_load_fetch: assert property (pc_load_o |-> fetch_start_o) else $error("fetch not with load");
  a_periph_init: assert property (periph_reset_o == core_reset_o) else $error("periph reset apart");
  a_reset_masked: assert property (core_reset_o |-> irq_masked_o && flag_register_o == 8'h80)
    else $error("flags wrong in reset");
endmodule
bind ress_seq ress_chk u_ress_chk (.*);
`default_nettype wire

// file: verification/ress_src.sv
// reset supervisor, boot select source and vector memory model
`timescale 1ns/1ps
`default_nettype none
module ress_src (
  input  wire logic        sys_clk_i,
  input  wire logic        rd_req_i,
  input  wire logic [15:0] rd_addr_i,
  input  wire logic [3:0]  dly_i,
  output var  logic        init_n_o = 1'b0,
  output var  logic        boot_o = 1'b1,
  output var  logic        rd_valid_o = 1'b0,
  output var  logic [7:0]  rd_data_o = 8'h00
);
  logic [3:0] wait_cnt = 4'h0;
  // vector bytes answer after dly_i idle cycles; idle bus toggles so stale data never matches
  always @(posedge sys_clk_i) begin
    rd_valid_o <= 1'b0;
    rd_data_o  <= ~rd_data_o;
    wait_cnt   <= (rd_req_i && !rd_valid_o) ? wait_cnt + 4'h1 : 4'h0;
    if (rd_req_i && !rd_valid_o && wait_cnt >= dly_i) begin
      rd_valid_o <= 1'b1;
      rd_data_o  <= rd_addr_i[0] ? 8'h34 : 8'h12;
      wait_cnt   <= 4'h0;
    end
  end
  // pin starts low so power-up and clock settling are covered
  task automatic hold_init(input int n, input logic b);
    @(posedge sys_clk_i);
    #1 boot_o = b;
    init_n_o = 1'b0;
    repeat (n) @(posedge sys_clk_i);
    #1 init_n_o = 1'b1;
  endtask
  task automatic set_boot(input logic b);
    @(posedge sys_clk_i);
    #1 boot_o = b;
  endtask
endmodule
`default_nettype wire

// file: verification/reset_exception_entry_sequencer_tb.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_exception_entry_sequencer_tb;
  logic sys_clk_i, rst_n_i, irq, done, busy;
  logic [3:0] dly;
  wire logic init_n, boot, rd_valid, core_rst, per_rst, rd_req, pc_load, fetch, exc, take, masked;
  wire logic [7:0] rd_data, flags;
  wire logic [15:0] rd_addr, pc;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  ress_src u_ress_src (.sys_clk_i(sys_clk_i), .rd_req_i(rd_req), .rd_addr_i(rd_addr), .dly_i(dly),
    .init_n_o(init_n), .boot_o(boot), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  ress_seq u_ress_seq (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .external_init_pin_n_i(init_n),
    .boot_select_pin_i(boot), .irq_req_i(irq), .insn_done_i(done), .exc_busy_i(busy),
    .rd_valid_i(rd_valid), .rd_data_i(rd_data), .core_reset_o(core_rst), .periph_reset_o(per_rst),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr), .program_counter_o(pc), .pc_load_o(pc_load),
    .fetch_start_o(fetch), .flag_register_o(flags), .reset_exc_o(exc), .irq_take_o(take),
    .irq_masked_o(masked));
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for the reset exception (sel 0) or the program counter load (sel 1)
  task automatic wait_sig(input logic sel, input int lim);
    n = 0;
    while ((sel ? pc_load : exc) !== 1'b1) begin
      @(posedge sys_clk_i);
      #1 n++;
      if (n > lim) begin
        n_mismatch++;
        $display("ERROR %0t: wait timed out", $time);
        print_verdict();
      end
    end
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic boot_high_run;
    irq = 1'b1;
    u_ress_src.hold_init(12, 1'b1);
    wait_sig(1'b0, 8);
    chk(n <= 4, 1);
    chk(flags, 8'h80);
    chk(per_rst, 1);
    wait_sig(1'b1, 40);
    chk(pc, 16'h1234);
    chk(fetch, 1);
    chk(take, 0);
  endtask
  task automatic first_insn;
    busy = 1'b1;
    chk(masked, 1);
    repeat (3) @(posedge sys_clk_i);
    #1 done = 1'b1;
    @(posedge sys_clk_i);
    #1 chk(take, 0);
    chk(core_rst, 0);
    @(posedge sys_clk_i);
    #1 chk(take, 0);
    busy = 1'b0;
    @(posedge sys_clk_i);
    #1 chk(take, 0);
    done = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1 chk(take, 0);
    chk(masked, 1);
  endtask
  // boot low: reset holds until boot rises, then the long count; restart drops it mid-count
  task automatic boot_low_run(input logic restart);
    u_ress_src.hold_init(10, 1'b0);
    repeat (50) @(posedge sys_clk_i);
    #1 chk(core_rst, 1);
    u_ress_src.set_boot(1'b1);
    if (restart) begin
      repeat (3000) @(posedge sys_clk_i);
      u_ress_src.hold_init(10, 1'b0);
      repeat (20) @(posedge sys_clk_i);
      #1 chk(core_rst, 1);
      u_ress_src.set_boot(1'b1);
    end
    wait_sig(1'b0, 8300);
    chk(n >= 8192 && n <= 8200, 1);
    wait_sig(1'b1, 80);
    chk(pc, 16'h1234);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    irq = 1'b0;
    done = 1'b0;
    busy = 1'b0;
    dly = 4'h1;
    repeat (3) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    boot_high_run();
    first_insn();
    dly = 4'h5;
    boot_low_run(1'b0);
    boot_low_run(1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
